// ===== src/psc_cfg.v
// pmbus slave holding the security, trim and start-up compensation command bank
`timescale 1ns/100ps
`default_nettype none
`include "psc_cfg_regs.vh"

// How it works
// - diagnostic dump reads eight buffer bytes
// - accepted setup write turns security on
// - setup reads return only zeros
// - correct unlock suspends security until reset
// - unlock command nacked while security off
// - 256-bit mask, one bit per command
// - locked masked commands other than setup and unlock have writes blocked
// - winding ratio: primary high, secondary low
// - eight-bit internal clock trim value
// - three signed multipliers scale rise slope
// - new slope acts on the next clock
// - capacitance over limit picks its multiplier
// - over third limit selects pid bank three
// - ramp start and end voltages stored
// - soft start adds percent to limit
module psc_cfg #(
   parameter [6:0] DEV_ADDR = 7'h40
) (
   input  wire        clock,
   input  wire        rst_n,
   input  wire        scl_in,
   input  wire        sda_in,
   output reg         sda_out,
   output reg         sda_oe,
   input  wire [63:0] diag_buffer,
   input  wire [7:0]  cap_estimate,
   input  wire [7:0]  ton_rise,
   input  wire        soft_start,
   input  wire [7:0]  current_limit_user,
   output reg  [16:0] ramp_slope,
   output reg         pid_bank3_sel,
   output reg  [10:0] current_limit,
   output reg  [7:0]  meas_v_start,
   output reg  [7:0]  meas_v_end,
   output reg  [3:0]  turns_primary,
   output reg  [3:0]  turns_secondary,
   output reg  [7:0]  clock_trim,
   output reg         security_on,
   output reg         security_suspended,
   output reg         ext_wr,
   output reg         ext_send,
   output reg  [7:0]  ext_cmd,
   output reg  [5:0]  ext_idx,
   output reg  [7:0]  ext_data
);

   localparam [8:0] S_IDLE  = 9'h001;
   localparam [8:0] S_ADDR  = 9'h002;
   localparam [8:0] S_ACKA  = 9'h004;
   localparam [8:0] S_CMD   = 9'h008;
   localparam [8:0] S_ACKC  = 9'h010;
   localparam [8:0] S_WR    = 9'h020;
   localparam [8:0] S_ACKW  = 9'h040;
   localparam [8:0] S_RD    = 9'h080;
   localparam [8:0] S_ACKR  = 9'h100;

   reg  [1:0]   scl_meta_q;
   reg  [1:0]   sda_meta_q;
   reg          scl_old_q;
   reg          sda_old_q;
   reg  [8:0]   state_q;
   reg  [3:0]   cnt_q;
   reg  [7:0]   sh_q;
   reg  [7:0]   tx_q;
   reg          rw_q;
   reg          host_nack_q;
   reg  [7:0]   cmd_q;
   reg  [5:0]   idx_q;
   reg          pend_q;
   reg  [95:0]  stage_q;
   reg  [47:0]  pwd_q;
   reg  [255:0] mask_q;
   reg  [7:0]   winding_q;
   reg  [7:0]   clkadj_q;
   reg  [63:0]  dlc_q;
   reg  [7:0]   boost_q;

   wire scl_s   = scl_meta_q[1];
   wire sda_s   = sda_meta_q[1];
   wire scl_ris = scl_s & ~scl_old_q;
   wire scl_fal = ~scl_s & scl_old_q;
   wire start_c = scl_s & scl_old_q & sda_old_q & ~sda_s;
   wire stop_c  = scl_s & scl_old_q & ~sda_old_q & sda_s;

   // the password and unlock commands themselves stay reachable, or a lock could never be lifted
   function blocked;
      input [7:0]   cmd;
      input [255:0] mask;
      input         lock;
      begin
         blocked = lock & mask[cmd] & (cmd != `PSC_CMD_SETUP) & (cmd != `PSC_CMD_UNLOCK);
      end
   endfunction

   wire lock_eff = security_on & ~security_suspended;
   wire cmd_blk  = blocked(cmd_q, mask_q, lock_eff);

   // read byte for the current index, or the next one while the host acknowledges
   wire [5:0] rd_idx = (state_q == S_ACKR) ? idx_q + 6'h01 : idx_q;
   reg  [7:0] rd_byte;
   always @* begin
      rd_byte = `PSC_UNMAPPED_READ;
      if (cmd_q == `PSC_CMD_DIAG) begin
         rd_byte = (rd_idx < `PSC_DIAG_BYTES) ? diag_buffer[rd_idx*8 +: 8] : `PSC_BYTE_RESET;
      end else if (cmd_q == `PSC_CMD_SETUP || cmd_q == `PSC_CMD_UNLOCK) begin
         rd_byte = `PSC_BYTE_RESET;
      end else if (cmd_q == `PSC_CMD_MASK) begin
         rd_byte = (rd_idx < `PSC_MASK_BYTES) ? mask_q[rd_idx*8 +: 8] : `PSC_BYTE_RESET;
      end else if (cmd_q == `PSC_CMD_WINDING) begin
         rd_byte = (rd_idx == 6'h00) ? winding_q : `PSC_BYTE_RESET;
      end else if (cmd_q == `PSC_CMD_CLKADJ) begin
         rd_byte = (rd_idx == 6'h00) ? clkadj_q : `PSC_BYTE_RESET;
      end else if (cmd_q == `PSC_CMD_DLC) begin
         rd_byte = (rd_idx < `PSC_DLC_BYTES) ? dlc_q[rd_idx*8 +: 8] : `PSC_BYTE_RESET;
      end else if (cmd_q == `PSC_CMD_BOOST) begin
         rd_byte = (rd_idx == 6'h00) ? boost_q : `PSC_BYTE_RESET;
      end
   end

   wire [5:0] idx_inc = (idx_q == `PSC_IDX_MAX) ? idx_q : idx_q + 6'h01;

   always @(posedge clock) begin
      if (!rst_n) begin
         scl_meta_q  <= 2'h3;
         sda_meta_q  <= 2'h3;
         scl_old_q   <= 1'b1;
         sda_old_q   <= 1'b1;
         state_q     <= S_IDLE;
         cnt_q       <= 4'h0;
         sh_q        <= 8'h00;
         tx_q        <= 8'h00;
         rw_q        <= 1'b0;
         host_nack_q <= 1'b0;
         cmd_q       <= 8'h00;
         idx_q       <= 6'h00;
         pend_q      <= 1'b0;
         stage_q     <= 96'h0;
         pwd_q       <= `PSC_PWD_DEFAULT;
         mask_q      <= `PSC_MASK_RESET;
         winding_q   <= `PSC_BYTE_RESET;
         clkadj_q    <= `PSC_BYTE_RESET;
         dlc_q       <= `PSC_DLC_RESET;
         boost_q     <= `PSC_BYTE_RESET;
         sda_out     <= 1'b0;
         sda_oe      <= 1'b0;
         security_on <= 1'b0;
         security_suspended <= 1'b0;
         ext_wr      <= 1'b0;
         ext_send    <= 1'b0;
         ext_cmd     <= 8'h00;
         ext_idx     <= 6'h00;
         ext_data    <= 8'h00;
      end else begin
         scl_meta_q <= {scl_meta_q[0], scl_in};
         sda_meta_q <= {sda_meta_q[0], sda_in};
         scl_old_q  <= scl_s;
         sda_old_q  <= sda_s;
         ext_wr     <= 1'b0;
         ext_send   <= 1'b0;
         if (start_c) begin
            state_q <= S_ADDR;
            cnt_q   <= 4'h0;
            idx_q   <= 6'h00;
            pend_q  <= 1'b0;
            sda_oe  <= 1'b0;
         end else if (stop_c) begin
            state_q <= S_IDLE;
            sda_oe  <= 1'b0;
            pend_q  <= 1'b0;
            if (pend_q && cmd_q == `PSC_CMD_SETUP && idx_q == `PSC_SETUP_BYTES &&
                stage_q[47:0] == pwd_q) begin
               pwd_q       <= stage_q[95:48];
               security_on <= 1'b1;
            end
            if (pend_q && cmd_q == `PSC_CMD_UNLOCK && idx_q == `PSC_PWD_BYTES &&
                stage_q[47:0] == pwd_q) begin
               security_suspended <= 1'b1;
            end
            if (pend_q && idx_q == 6'h00 && !cmd_blk && cmd_q[7:4] != 4'hF) begin
               ext_send <= 1'b1;
               ext_cmd  <= cmd_q;
            end
         end else if (scl_ris) begin
            if (state_q == S_ACKR) begin
               host_nack_q <= sda_s;
            end else if (state_q != S_IDLE) begin
               sh_q  <= {sh_q[6:0], sda_s};
               cnt_q <= cnt_q + 4'h1;
            end
         end else if (scl_fal) begin
            case (state_q)
               S_ADDR: begin
                  if (cnt_q == 4'h8) begin
                     if (sh_q[7:1] == DEV_ADDR) begin
                        state_q <= S_ACKA;
                        rw_q    <= sh_q[0];
                        sda_oe  <= 1'b1;
                     end else begin
                        state_q <= S_IDLE;
                     end
                  end
               end
               S_ACKA: begin
                  cnt_q <= 4'h0;
                  if (rw_q) begin
                     tx_q    <= rd_byte;
                     sda_oe  <= ~rd_byte[7];
                     state_q <= S_RD;
                  end else begin
                     sda_oe  <= 1'b0;
                     state_q <= S_CMD;
                  end
               end
               S_CMD: begin
                  if (cnt_q == 4'h8) begin
                     cmd_q <= sh_q;
                     idx_q <= 6'h00;
                     if (sh_q == `PSC_CMD_UNLOCK && !security_on) begin
                        state_q <= S_IDLE;
                     end else begin
                        state_q <= S_ACKC;
                        sda_oe  <= 1'b1;
                        pend_q  <= 1'b1;
                     end
                  end
               end
               S_ACKC, S_ACKW: begin
                  sda_oe  <= 1'b0;
                  cnt_q   <= 4'h0;
                  state_q <= S_WR;
               end
               S_WR: begin
                  if (cnt_q == 4'h8) begin
                     if (cmd_blk) begin
                        state_q <= S_IDLE;
                        pend_q  <= 1'b0;
                     end else begin
                        state_q <= S_ACKW;
                        sda_oe  <= 1'b1;
                        idx_q   <= idx_inc;
                        if ((cmd_q == `PSC_CMD_SETUP || cmd_q == `PSC_CMD_UNLOCK) &&
                            idx_q < `PSC_SETUP_BYTES) begin
                           stage_q[idx_q*8 +: 8] <= sh_q;
                        end
                        if (cmd_q == `PSC_CMD_MASK && idx_q < `PSC_MASK_BYTES) begin
                           mask_q[idx_q*8 +: 8] <= sh_q;
                        end
                        if (cmd_q == `PSC_CMD_WINDING && idx_q == 6'h00) begin
                           winding_q <= sh_q;
                        end
                        if (cmd_q == `PSC_CMD_CLKADJ && idx_q == 6'h00) begin
                           clkadj_q <= sh_q;
                        end
                        if (cmd_q == `PSC_CMD_DLC && idx_q < `PSC_DLC_BYTES) begin
                           dlc_q[idx_q*8 +: 8] <= sh_q;
                        end
                        if (cmd_q == `PSC_CMD_BOOST && idx_q == 6'h00) begin
                           boost_q <= sh_q;
                        end
                        if (cmd_q[7:4] != 4'hF) begin
                           ext_wr   <= 1'b1;
                           ext_cmd  <= cmd_q;
                           ext_idx  <= idx_q;
                           ext_data <= sh_q;
                        end
                     end
                  end
               end
               S_RD: begin
                  if (cnt_q == 4'h8) begin
                     sda_oe  <= 1'b0;
                     state_q <= S_ACKR;
                  end else begin
                     tx_q   <= {tx_q[6:0], 1'b0};
                     sda_oe <= ~tx_q[6];
                  end
               end
               S_ACKR: begin
                  if (host_nack_q) begin
                     state_q <= S_IDLE;
                  end else begin
                     idx_q   <= idx_inc;
                     tx_q    <= rd_byte;
                     sda_oe  <= ~rd_byte[7];
                     cnt_q   <= 4'h0;
                     state_q <= S_RD;
                  end
               end
               default: begin
                  state_q <= S_IDLE;
               end
            endcase
         end
      end
   end

   // start-up compensation; recomputed and registered every cycle so a new choice acts on the next clock
   reg  [7:0]  k_sel;
   reg         bank3;
   wire [16:0] slope_full = $signed({1'b0, ton_rise}) * $signed(k_sel);
   wire [15:0] boost_add  = (current_limit_user * boost_q) / `PSC_PERCENT;
   always @* begin
      k_sel = `PSC_K_UNITY;
      bank3 = 1'b0;
      if (cap_estimate > dlc_q[`PSC_DLC_LIM3]) begin
         k_sel = dlc_q[`PSC_DLC_K3];
         bank3 = 1'b1;
      end else if (cap_estimate > dlc_q[`PSC_DLC_LIM2]) begin
         k_sel = dlc_q[`PSC_DLC_K2];
      end else if (cap_estimate > dlc_q[`PSC_DLC_LIM1]) begin
         k_sel = dlc_q[`PSC_DLC_K1];
      end
   end

   always @(posedge clock) begin
      if (!rst_n) begin
         ramp_slope      <= 17'h0;
         pid_bank3_sel   <= 1'b0;
         current_limit   <= 11'h0;
         meas_v_start    <= 8'h00;
         meas_v_end      <= 8'h00;
         turns_primary   <= 4'h0;
         turns_secondary <= 4'h0;
         clock_trim      <= 8'h00;
      end else begin
         ramp_slope      <= $signed(slope_full) >>> `PSC_K_FRAC;
         pid_bank3_sel   <= bank3;
         current_limit   <= soft_start ? {3'h0, current_limit_user} + boost_add[10:0]
                                       : {3'h0, current_limit_user};
         meas_v_start    <= dlc_q[`PSC_DLC_VSTART];
         meas_v_end      <= dlc_q[`PSC_DLC_VEND];
         turns_primary   <= winding_q[`PSC_WIND_PRI];
         turns_secondary <= winding_q[`PSC_WIND_SEC];
         clock_trim      <= clkadj_q;
      end
   end

endmodule // psc_cfg
`default_nettype wire

// ===== common/psc_cfg_regs.vh
// command codes, field layouts and reset values of the security and start-up command bank
`ifndef PSC_CFG_REGS_VH
`define PSC_CFG_REGS_VH

`define PSC_CMD_DIAG        8'hF0
`define PSC_CMD_SETUP       8'hF1
`define PSC_CMD_UNLOCK      8'hF2
`define PSC_CMD_MASK        8'hF4
`define PSC_CMD_WINDING     8'hF5
`define PSC_CMD_CLKADJ      8'hF6
`define PSC_CMD_DLC         8'hF7
`define PSC_CMD_BOOST       8'hF8

`define PSC_DIAG_BYTES      6'h08
`define PSC_SETUP_BYTES     6'h0C
`define PSC_PWD_BYTES       6'h06
`define PSC_MASK_BYTES      6'h20
`define PSC_DLC_BYTES       6'h08
`define PSC_IDX_MAX         6'h3F

`define PSC_PWD_DEFAULT     48'h303030303030
`define PSC_MASK_RESET      256'h0
`define PSC_BYTE_RESET      8'h00
`define PSC_DLC_RESET       64'h0
`define PSC_UNMAPPED_READ   8'hFF

// startup_load_comp_cfg fields
`define PSC_DLC_K3          63:56
`define PSC_DLC_LIM3        55:48
`define PSC_DLC_K2          47:40
`define PSC_DLC_LIM2        39:32
`define PSC_DLC_K1          31:24
`define PSC_DLC_LIM1        23:16
`define PSC_DLC_VEND        15:8
`define PSC_DLC_VSTART      7:0

// winding_ratio fields
`define PSC_WIND_PRI        7:4
`define PSC_WIND_SEC        3:0

// ramp multipliers are signed with this many fraction bits; unity used up to and including the first limit
`define PSC_K_FRAC          4
`define PSC_K_UNITY         8'h10
`define PSC_PERCENT         16'h0064

`endif

// ===== verification/psc_cfg_sva.sv
// assertion checker for the security and start-up command bank
`timescale 1ns/100ps
`default_nettype none
module psc_cfg_sva (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        scl_in,
   input wire logic        sda_oe,
   input wire logic [7:0]  cap_estimate,
   input wire logic [7:0]  ton_rise,
   input wire logic        soft_start,
   input wire logic [7:0]  current_limit_user,
   input wire logic [16:0] ramp_slope,
   input wire logic        pid_bank3_sel,
   input wire logic [10:0] current_limit,
   input wire logic        security_on,
   input wire logic        security_suspended,
   input wire logic        ext_wr,
   input wire logic [7:0]  ext_cmd
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   sequence s_oe_move;
      sda_oe != $past(sda_oe);
   endsequence
   property p_sec_hold;
      security_on |=> security_on;
   endproperty
   a_sec_hold: assert property (p_sec_hold) else $error("security dropped");
   property p_sec_stop;
      $rose(security_on) |-> scl_in;
   endproperty
   a_sec_stop: assert property (p_sec_stop) else $error("security set off stop");
   property p_susp_hold;
      security_suspended |=> security_suspended;
   endproperty
   a_susp_hold: assert property (p_susp_hold) else $error("suspend dropped");
   property p_susp_gate;
      $rose(security_suspended) |-> security_on && scl_in;
   endproperty
   a_susp_gate: assert property (p_susp_gate) else $error("suspend while off");
   property p_current_limit;
      !soft_start |=> current_limit == {3'h0, $past(current_limit_user)};
   endproperty
   a_current_limit: assert property (p_current_limit) else $error("limit not user value");
   property p_boost;
      soft_start |=> current_limit >= {3'h0, $past(current_limit_user)};
   endproperty
   a_boost: assert property (p_boost) else $error("boosted limit too low");
   property p_unity;
      cap_estimate == 8'h00 |=> ramp_slope == {9'h000, $past(ton_rise)};
   endproperty
   a_unity: assert property (p_unity) else $error("slope not unity");
   property p_no_pid;
      cap_estimate == 8'h00 |=> !pid_bank3_sel;
   endproperty
   a_no_pid: assert property (p_no_pid) else $error("bank three picked");
   property p_oe_scl;
      s_oe_move |-> !scl_in;
   endproperty
   a_oe_scl: assert property (p_oe_scl) else $error("sda moved in clock high");
   property p_ext_fx;
      ext_wr |-> ext_cmd[7:4] != 4'hF;
   endproperty
   a_ext_fx: assert property (p_ext_fx) else $error("bank command forwarded");
endmodule // psc_cfg_sva
bind psc_cfg psc_cfg_sva chk_u (.clock(clock), .rst_n(rst_n), .scl_in(scl_in),
   .sda_oe(sda_oe), .cap_estimate(cap_estimate), .ton_rise(ton_rise),
   .soft_start(soft_start), .current_limit_user(current_limit_user),
   .ramp_slope(ramp_slope), .pid_bank3_sel(pid_bank3_sel),
   .current_limit(current_limit), .security_on(security_on),
   .security_suspended(security_suspended), .ext_wr(ext_wr), .ext_cmd(ext_cmd));
`default_nettype wire

// ===== verification/psc_host_model.sv
// management bus host model, open drain on sda
`timescale 1ns/100ps
`default_nettype none
module psc_host_model #(
   parameter [6:0] ADDR = 7'h40
) (
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   // scl stands high between frames; each bit is 160 ns
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic bit_io(input logic b, output logic r);
      #40 sda_low = ~b;
      #40 scl = 1'b1;
      #40 r = sda;
      #40 scl = 1'b0;
   endtask
   task automatic start;
      #40 sda_low = 1'b0;
      #40 scl = 1'b1;
      #80 sda_low = 1'b1;
      #80 scl = 1'b0;
   endtask
   task automatic stop;
      #40 sda_low = 1'b1;
      #40 scl = 1'b1;
      #80 sda_low = 1'b0;
      #80;
   endtask
   task automatic tx(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // stops sending at the first refused byte
   task automatic write(input logic [7:0] c, input int n, input logic [255:0] d,
                        output logic nak);
      logic a;
      start();
      tx({ADDR, 1'b0}, a);
      if (a) tx(c, a);
      for (int i = 0; i < n && a; i++) tx(d[8*i +: 8], a);
      nak = ~a;
      stop();
   endtask
   task automatic read(input logic [7:0] c, input int n, output logic [63:0] d);
      logic a;
      logic r;
      d = 64'h0;
      start();
      tx({ADDR, 1'b0}, a);
      tx(c, a);
      start();
      tx({ADDR, 1'b1}, a);
      for (int i = 0; i < 8 * n; i++) begin
         bit_io(1'b1, r);
         d[8*(i/8) + 7 - i%8] = r;
         if (i % 8 == 7) bit_io(i == 8 * n - 1, r);
      end
      stop();
   endtask
endmodule // psc_host_model
`default_nettype wire

// ===== verification/test_psc_cfg.sv
// self-checking bench for the security and start-up command bank
`timescale 1ns/100ps
`default_nettype none
`include "psc_cfg_regs.vh"
module test_psc_cfg;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [63:0] diag_buffer = 64'h0;
   logic [7:0]  cap_estimate = 8'h00;
   logic [7:0]  ton_rise = 8'h00;
   logic        soft_start = 1'b0;
   logic [7:0]  current_limit_user = 8'h00;
   logic        nk;
   logic [15:0] ext_seen = 16'h0000;
   logic [7:0]  send_seen = 8'h00;
   logic [5:0]  idx_seen = 6'h00;
   logic [7:0]  capv [4] = '{8'h0A, 8'h0B, 8'h15, 8'h1F};
   logic [17:0] expv [4] = '{18'h00040, 18'h00080, 18'h000C0, 18'h3FFC0};
   int          errors = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   wire         scl, sda, sda_low, sda_out, sda_oe, pid_bank3_sel, security_on;
   wire         security_suspended, ext_wr, ext_send;
   wire [16:0]  ramp_slope;
   wire [10:0]  current_limit;
   wire [7:0]   meas_v_start, meas_v_end, clock_trim, ext_cmd, ext_data;
   wire [3:0]   turns_primary, turns_secondary;
   wire [5:0]   ext_idx;
   // sda has a pull-up: high unless someone pulls it
   assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;
   psc_host_model #(.ADDR(7'h40)) host_u (.scl(scl), .sda_low(sda_low), .sda(sda));
   psc_cfg #(.DEV_ADDR(7'h40)) dut_u (.clock(clock), .rst_n(rst_n), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .diag_buffer(diag_buffer),
      .cap_estimate(cap_estimate), .ton_rise(ton_rise), .soft_start(soft_start),
      .current_limit_user(current_limit_user), .ramp_slope(ramp_slope),
      .pid_bank3_sel(pid_bank3_sel), .current_limit(current_limit),
      .meas_v_start(meas_v_start), .meas_v_end(meas_v_end),
      .turns_primary(turns_primary), .turns_secondary(turns_secondary),
      .clock_trim(clock_trim), .security_on(security_on),
      .security_suspended(security_suspended), .ext_wr(ext_wr), .ext_send(ext_send),
      .ext_cmd(ext_cmd), .ext_idx(ext_idx), .ext_data(ext_data));
   always #5 clock = ~clock;
   always @(posedge clock) begin
      if (ext_wr) begin
         ext_seen <= {ext_cmd, ext_data};
         idx_seen <= ext_idx;
      end
      if (ext_send) send_seen <= ext_cmd;
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         errors++;
         final_report();
      end
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // frames start on the falling clock edge so no pin moves at a sampling edge
   task automatic w(input logic [7:0] c, input int n, input logic [255:0] d);
      @(negedge clock);
      host_u.write(c, n, d, nk);
   endtask
   task automatic rd_cmd(input logic [7:0] c, input int n, output logic [63:0] d);
      @(negedge clock);
      host_u.read(c, n, d);
   endtask
   task automatic settle;
      @(posedge clock);
      #1;
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      logic [63:0] rd;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      #1;
      chk({security_on, security_suspended, clock_trim, turns_primary}, 64'h0);
      w(`PSC_CMD_WINDING, 1, 256'hA3);
      w(`PSC_CMD_CLKADJ, 1, 256'h5C);
      settle();
      chk({turns_primary, turns_secondary, clock_trim}, 64'hA35C);
      rd_cmd(`PSC_CMD_WINDING, 1, rd);
      chk(rd, 64'hA3);
      rd_cmd(8'hF3, 1, rd);
      chk(rd, {56'h0, `PSC_UNMAPPED_READ});
      w(`PSC_CMD_UNLOCK, 6, `PSC_PWD_DEFAULT);
      chk({nk, security_suspended}, 64'h2);
      @(posedge clock);
      diag_buffer <= 64'h8877665544332211;
      rd_cmd(`PSC_CMD_DIAG, 8, rd);
      chk(rd, 64'h8877665544332211);
      $display("test registers done");
      w(`PSC_CMD_DLC, 8, 256'hF01E3014200A7C12);
      @(posedge clock);
      ton_rise <= 8'h40;
      #1;
      chk({meas_v_end, meas_v_start}, 64'h7C12);
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         cap_estimate <= capv[i];
         repeat (2) @(posedge clock);
         #1;
         chk({pid_bank3_sel, ramp_slope}, expv[i]);
      end
      w(`PSC_CMD_BOOST, 1, 256'h32);
      @(posedge clock);
      current_limit_user <= 8'h64;
      soft_start <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      chk(current_limit, 64'h96);
      $display("test start-up done");
      w(`PSC_CMD_MASK, 32, (256'h20 << 240) | 256'h08);
      w(`PSC_CMD_SETUP, 12, {48'h464544434241, 48'h313131313131});
      settle();
      chk(security_on, 64'h0);
      w(`PSC_CMD_SETUP, 12, {48'h464544434241, `PSC_PWD_DEFAULT});
      settle();
      chk(security_on, 64'h1);
      rd_cmd(`PSC_CMD_SETUP, 8, rd);
      chk(rd, 64'h0);
      w(`PSC_CMD_WINDING, 1, 256'h11);
      chk(nk, 64'h1);
      w(8'h03, 0, 256'h0);
      w(8'h21, 1, 256'h55);
      settle();
      chk({turns_primary, turns_secondary, send_seen, ext_seen}, 64'hA3002155);
      w(`PSC_CMD_UNLOCK, 6, `PSC_PWD_DEFAULT);
      settle();
      chk(security_suspended, 64'h0);
      w(`PSC_CMD_UNLOCK, 6, 256'h464544434241);
      w(`PSC_CMD_WINDING, 1, 256'h11);
      w(8'h03, 0, 256'h0);
      settle();
      chk({security_suspended, turns_primary, turns_secondary, send_seen}, 64'h11103);
      // bank three is selected before its coefficients are touched
      w(8'hD5, 1, 256'h03);
      settle();
      chk(ext_seen, 64'hD503);
      w(8'hE8, 2, 256'hBBAA);
      settle();
      chk({ext_seen, idx_seen}, {16'hE8BB, 6'h01});
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      settle();
      chk({security_on, security_suspended}, 64'h0);
      $display("test security done");
      final_report();
   end
endmodule // test_psc_cfg
`default_nettype wire
